// >>> inc/psr_pkg.sv
package psr_pkg;
    // ****
    // register indexes (byte address = index * 4)
    // ****
    localparam logic [9:0] IDX_VMAP_A    = 10'h002;
    localparam logic [9:0] IDX_VMAP_B    = 10'h003;
    localparam logic [9:0] IDX_CLK_EV    = 10'h004;
    localparam logic [9:0] IDX_BUS_RELOC = 10'h005;
    localparam logic [9:0] IDX_EV_CTRL   = 10'h006;
    localparam logic [9:0] IDX_VPORT     = 10'h010;
    localparam logic [9:0] IDX_PPORT     = 10'h040;
    localparam int         PPORT_SPAN    = 32;
    localparam logic [1:0] SEL_DIR       = 2'h0;
    localparam logic [1:0] SEL_OUT       = 2'h1;
    localparam logic [1:0] SEL_IN        = 2'h2;
    localparam logic [1:0] SEL_FLAGS     = 2'h3;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [7:0] BUS_RW_MASK   = 8'h0F;
    localparam logic [7:0] EVC_RW_MASK   = 8'h07;
    localparam logic [7:0] FLAG_RW_MASK  = 8'h03;
    // ****
    // field positions
    // ****
    localparam int CLK_PORT_LSB = 0;
    localparam int CLK_SRC_LSB  = 2;
    localparam int EV_PORT_LSB  = 4;
    localparam int PIN_ALT_BIT  = 7;
    localparam int CS_LSB       = 0;
    localparam int ADDR_LSB     = 2;
    // ****
    // codes
    // ****
    localparam logic [3:0] PORT_C = 4'h2;
    localparam logic [3:0] PORT_D = 4'h3;
    localparam logic [3:0] PORT_E = 4'h4;
    localparam logic [3:0] PORT_F = 4'h5;
    localparam logic [3:0] PORT_H = 4'h7;
    localparam logic [3:0] PORT_L = 4'hA;
    localparam logic [2:0] PIN_DEFAULT = 3'h7;
    localparam logic [2:0] PIN_ALT     = 3'h4;
    localparam logic [2:0] ISC_BOTH = 3'h0;
    localparam logic [2:0] ISC_RISE = 3'h1;
    localparam logic [2:0] ISC_FALL = 3'h2;
    localparam logic [2:0] ISC_LOW  = 3'h3;
    localparam logic [2:0] ISC_OFF  = 3'h7;
    localparam logic [1:0] CLK_1X = 2'h0;
    localparam logic [1:0] CLK_2X = 2'h1;
    localparam logic [1:0] CLK_4X = 2'h2;
    localparam logic [2:0] BM_SDRAM      = 3'h0;
    localparam logic [2:0] BM_SRAM       = 3'h1;
    localparam logic [2:0] BM_SRAM_LPC   = 3'h2;
    localparam logic [2:0] BM_NO_LATCH   = 3'h3;
    localparam logic [2:0] BM_ONE_LATCH  = 3'h4;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_RESP = 2'b10
    } psr_phase_t;

    typedef struct packed {
        logic       port_hit;
        logic       cfg_hit;
        logic [3:0] port;
        logic [1:0] sel;
    } psr_tgt_t;
endpackage : psr_pkg

// >>> src/psr_sense.sv
`timescale 1ns/1ns
module psr_sense (
    input  wire logic [7:0]  pin_now,   // pin levels this cycle
    input  wire logic [7:0]  pin_prev,  // pin levels last cycle
    input  wire logic [23:0] sense_cfg, // three sense bits per pin
    input  wire logic [7:0]  mask0,     // pins feeding interrupt 0
    input  wire logic [7:0]  mask1,     // pins feeding interrupt 1
    output logic      [1:0]  flag_set,  // per-interrupt set pulse
    output logic      [7:0]  buf_en     // digital input buffer on
);
    logic [7:0] hit;

    for (genvar i = 0; i < 8; i++) begin : g_pin
        always_comb begin
            case (sense_cfg[3*i +: 3])
                psr_pkg::ISC_BOTH: hit[i] = pin_now[i] ^ pin_prev[i];
                psr_pkg::ISC_RISE: hit[i] = pin_now[i] & ~pin_prev[i];
                psr_pkg::ISC_FALL: hit[i] = ~pin_now[i] & pin_prev[i];
                psr_pkg::ISC_LOW:  hit[i] = ~pin_now[i];
                default:           hit[i] = 1'b0;
            endcase
            buf_en[i] = (sense_cfg[3*i +: 3] != psr_pkg::ISC_OFF);
        end
    end

    assign flag_set[0] = |(hit & mask0);
    assign flag_set[1] = |(hit & mask1);
endmodule : psr_sense

// >>> src/psr_pin_mux.sv
`timescale 1ns/1ns
module psr_pin_mux (
    input  wire logic [3:0] port_id,   // this port's number
    input  wire logic [7:0] out_val,   // output-value register
    input  wire logic       addr_en,   // relocated address active
    input  wire logic [3:0] addr_port, // port taking the address
    input  wire logic       addr_half, // only pins 4 to 7
    input  wire logic [7:0] addr_byte, // address bits to drive
    input  wire logic       cs_en,     // relocated chip selects active
    input  wire logic [3:0] cs_port,   // port taking chip selects
    input  wire logic [3:0] cs_bits,   // chip select levels
    input  wire logic       ev_en,     // event output active
    input  wire logic [3:0] ev_port,   // port taking the event
    input  wire logic       ev_bit,    // chosen event channel
    input  wire logic       clk_en,    // clock output active
    input  wire logic [3:0] clk_port,  // port taking the clock
    input  wire logic       clk_bit,   // chosen peripheral clock
    input  wire logic [2:0] pin_sel,   // pin for clock and event
    output logic      [7:0] pin_val    // value offered to the pins
);
    always_comb begin
        pin_val = out_val;
        if (addr_en && port_id == addr_port) begin
            if (addr_half) begin
                pin_val[7:4] = addr_byte[3:0];
            end else begin
                pin_val = addr_byte;
            end
        end
        if (cs_en && port_id == cs_port) begin
            pin_val[7:4] = cs_bits;
        end
        if (ev_en && port_id == ev_port) begin
            pin_val[pin_sel] = ev_bit;
        end
        // clock is applied last so it wins a shared pin
        if (clk_en && port_id == clk_port) begin
            pin_val[pin_sel] = clk_bit;
        end
    end
endmodule : psr_pin_mux

// >>> src/psr_port_routing.sv
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module psr_port_routing #(
    parameter int NPORT = 16
) (
    input  wire logic                 pclk,          // bus clock
    input  wire logic                 presetn,       // async reset, low
    input  wire logic                 psel,          // apb select
    input  wire logic                 penable,       // apb access phase
    input  wire logic                 pwrite,        // apb write
    input  wire logic [11:0]          paddr,         // apb byte address
    input  wire logic [31:0]          pwdata,        // apb write data
    output logic      [31:0]          prdata,        // apb read data
    output logic                      pready,        // apb ready
    output logic                      pslverr,       // apb error
    input  wire logic [NPORT*8-1:0]   pin_in,        // pin levels
    output logic      [NPORT*8-1:0]   pin_out,       // pin drive values
    output logic      [NPORT*8-1:0]   pin_oe,        // pin drive enables
    input  wire logic [NPORT*24-1:0]  sense_cfg,     // per-pin sense setting
    input  wire logic [NPORT*8-1:0]   irq0_src_mask, // interrupt 0 sources
    input  wire logic [NPORT*8-1:0]   irq1_src_mask, // interrupt 1 sources
    output logic      [NPORT*2-1:0]   port_irq_flag, // pending flags
    input  wire logic                 clk_per_1x,    // peripheral clock
    input  wire logic                 clk_per_2x,    // double-rate clock
    input  wire logic                 clk_per_4x,    // quad-rate clock
    input  wire logic [7:0]           ev_chan,       // event channels
    input  wire logic                 bus_enable,    // external bus on
    input  wire logic                 bus_four_port, // four-port mode
    input  wire logic [2:0]           bus_mode,      // memory type
    input  wire logic [23:0]          bus_addr,      // bus address
    input  wire logic [3:0]           bus_chipsel    // chip selects
);
    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic [NPORT-1:0][7:0] dir;
        logic [NPORT-1:0][7:0] outv;
        logic [NPORT-1:0][7:0] inv;
        logic [NPORT-1:0][1:0] flags;
        logic [NPORT-1:0][7:0] pins;
        logic [7:0]            vmap_a;
        logic [7:0]            vmap_b;
        logic [7:0]            clk_ev;
        logic [7:0]            reloc;
        logic [7:0]            ev_ctrl;
        logic [31:0]           rdata;
        logic                  err;
        psr_pkg::psr_phase_t   phase;
    } psr_state_t;

    psr_state_t s_q;
    psr_state_t s_d;

    // ********************************
    // decoding
    // ********************************
    function automatic logic [3:0] out_port(input logic [1:0] code);
        case (code)
            2'h1:    out_port = psr_pkg::PORT_C;
            2'h2:    out_port = psr_pkg::PORT_D;
            default: out_port = psr_pkg::PORT_E;
        endcase
    endfunction : out_port

    function automatic psr_pkg::psr_tgt_t decode(input logic [9:0] idx,
                                                 input logic [7:0] map_a,
                                                 input logic [7:0] map_b);
        psr_pkg::psr_tgt_t t;
        logic [9:0]        rel;
        t   = '0;
        rel = idx - psr_pkg::IDX_PPORT;
        if (idx >= psr_pkg::IDX_VPORT && idx < psr_pkg::IDX_VPORT + 10'h010) begin
            t.sel = idx[1:0];
            case (idx[3:2])
                2'h0:    t.port = map_a[3:0];
                2'h1:    t.port = map_a[7:4];
                2'h2:    t.port = map_b[3:0];
                default: t.port = map_b[7:4];
            endcase
            t.port_hit = (32'(t.port) < NPORT);
        end else if (idx >= psr_pkg::IDX_PPORT && rel[4] == 1'b0 && rel[1:0] == 2'h0
                     && 32'(rel[9:5]) < NPORT) begin
            t.port     = rel[8:5];
            t.sel      = rel[3:2];
            t.port_hit = 1'b1;
        end else if (idx >= psr_pkg::IDX_VMAP_A && idx <= psr_pkg::IDX_EV_CTRL) begin
            t.cfg_hit = 1'b1;
        end
        return t;
    endfunction : decode

    // ********************************
    // routing sources
    // ********************************
    psr_pkg::psr_tgt_t  tgt;
    logic               clk_bit;
    logic               clk_en;
    logic               ev_en;
    logic [2:0]         pin_sel;
    logic [1:0]         addr_code;
    logic               addr_en;
    logic               addr_half;
    logic [3:0]         addr_port;
    logic [7:0]         addr_byte;
    logic [3:0]         cs_port;
    logic [NPORT*8-1:0] in_vis;
    logic [1:0]         set_f [NPORT];
    logic [7:0]         mux_v [NPORT];

    assign tgt       = decode(paddr[11:2], s_q.vmap_a, s_q.vmap_b);
    assign clk_en    = s_q.clk_ev[psr_pkg::CLK_PORT_LSB +: 2] != 2'h0;
    assign ev_en     = s_q.clk_ev[psr_pkg::EV_PORT_LSB +: 2] != 2'h0;
    assign addr_code = s_q.reloc[psr_pkg::ADDR_LSB +: 2];
    assign addr_half = addr_code[1];
    assign addr_port = addr_code[0] ? psr_pkg::PORT_E : psr_pkg::PORT_F;

    always_comb begin
        if (s_q.clk_ev[psr_pkg::PIN_ALT_BIT]) begin
            pin_sel = psr_pkg::PIN_ALT;
        end else begin
            pin_sel = psr_pkg::PIN_DEFAULT;
        end
        case (s_q.clk_ev[psr_pkg::CLK_SRC_LSB +: 2])
            psr_pkg::CLK_1X: clk_bit = clk_per_1x;
            psr_pkg::CLK_2X: clk_bit = clk_per_2x;
            psr_pkg::CLK_4X: clk_bit = clk_per_4x;
            default:         clk_bit = 1'b0;
        endcase
        case (s_q.reloc[psr_pkg::CS_LSB +: 2])
            2'h0:    cs_port = psr_pkg::PORT_H;
            2'h1:    cs_port = psr_pkg::PORT_L;
            2'h2:    cs_port = psr_pkg::PORT_F;
            default: cs_port = psr_pkg::PORT_E;
        endcase
        // the half-port selection has no byte for the no-latch and one-latch memories
        addr_byte = 8'h00;
        addr_en   = bus_enable && bus_four_port;
        case (bus_mode)
            psr_pkg::BM_SDRAM: begin
                addr_byte = {4'h0, bus_addr[11:8]};
            end
            psr_pkg::BM_SRAM, psr_pkg::BM_SRAM_LPC: begin
                addr_byte = addr_half ? {4'h0, bus_addr[19:16]} : bus_addr[23:16];
            end
            psr_pkg::BM_NO_LATCH, psr_pkg::BM_ONE_LATCH: begin
                addr_byte = bus_addr[15:8];
                addr_en   = addr_en && !addr_half;
            end
            default: addr_en = 1'b0;
        endcase
    end

    // ********************************
    // per-port logic
    // ********************************
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        logic [7:0] buf_en;

        psr_sense u_sense (
            .pin_now   (pin_in[8*p +: 8]),
            .pin_prev  (s_q.inv[p]),
            .sense_cfg (sense_cfg[24*p +: 24]),
            .mask0     (irq0_src_mask[8*p +: 8]),
            .mask1     (irq1_src_mask[8*p +: 8]),
            .flag_set  (set_f[p]),
            .buf_en    (buf_en)
        );

        assign in_vis[8*p +: 8] = s_q.inv[p] & buf_en;

        psr_pin_mux u_mux (
            .port_id   (4'(p)),
            .out_val   (s_q.outv[p]),
            .addr_en   (addr_en),
            .addr_port (addr_port),
            .addr_half (addr_half),
            .addr_byte (addr_byte),
            .cs_en     (bus_enable),
            .cs_port   (cs_port),
            .cs_bits   (bus_chipsel),
            .ev_en     (ev_en),
            .ev_port   (out_port(s_q.clk_ev[psr_pkg::EV_PORT_LSB +: 2])),
            .ev_bit    (ev_chan[s_q.ev_ctrl[2:0]]),
            .clk_en    (clk_en),
            .clk_port  (out_port(s_q.clk_ev[psr_pkg::CLK_PORT_LSB +: 2])),
            .clk_bit   (clk_bit),
            .pin_sel   (pin_sel),
            .pin_val   (mux_v[p])
        );
    end

    // ********************************
    // next state
    // ********************************
    logic       setup;
    logic       wr_go;
    logic [7:0] wb;
    logic [7:0] rb;

    assign setup = psel && !penable;
    assign wr_go = psel && penable && pwrite && s_q.phase == psr_pkg::PH_RESP;
    assign wb    = pwdata[7:0];

    always_comb begin
        s_d = s_q;
        for (int p = 0; p < NPORT; p++) begin
            s_d.inv[p]  = pin_in[8*p +: 8];
            s_d.pins[p] = mux_v[p];
        end
        // write-one clears first, then new events set: a set never gets lost
        if (wr_go && tgt.port_hit) begin
            case (tgt.sel)
                psr_pkg::SEL_DIR: s_d.dir[tgt.port]  = wb;
                psr_pkg::SEL_OUT: s_d.outv[tgt.port] = wb;
                psr_pkg::SEL_FLAGS: begin
                    s_d.flags[tgt.port] = s_q.flags[tgt.port] & ~wb[1:0];
                end
                default: ;
            endcase
        end
        for (int p = 0; p < NPORT; p++) begin
            s_d.flags[p] = s_d.flags[p] | set_f[p];
        end
        if (wr_go && tgt.cfg_hit) begin
            if (paddr[11:2] == psr_pkg::IDX_VMAP_A) begin
                s_d.vmap_a = wb;
            end else if (paddr[11:2] == psr_pkg::IDX_VMAP_B) begin
                s_d.vmap_b = wb;
            end else if (paddr[11:2] == psr_pkg::IDX_CLK_EV) begin
                s_d.clk_ev = wb;
            end else if (paddr[11:2] == psr_pkg::IDX_BUS_RELOC) begin
                s_d.reloc = wb & psr_pkg::BUS_RW_MASK;
            end else begin
                s_d.ev_ctrl = wb & psr_pkg::EVC_RW_MASK;
            end
        end
        // read data is fetched during setup so it can come from a register
        rb = 8'h00;
        if (tgt.port_hit) begin
            case (tgt.sel)
                psr_pkg::SEL_DIR: rb = s_q.dir[tgt.port];
                psr_pkg::SEL_OUT: rb = s_q.outv[tgt.port];
                psr_pkg::SEL_IN:  rb = in_vis[8*tgt.port +: 8];
                default: rb = {6'h00, s_q.flags[tgt.port]} & psr_pkg::FLAG_RW_MASK;
            endcase
        end else if (paddr[11:2] == psr_pkg::IDX_VMAP_A) begin
            rb = s_q.vmap_a;
        end else if (paddr[11:2] == psr_pkg::IDX_VMAP_B) begin
            rb = s_q.vmap_b;
        end else if (paddr[11:2] == psr_pkg::IDX_CLK_EV) begin
            rb = s_q.clk_ev;
        end else if (paddr[11:2] == psr_pkg::IDX_BUS_RELOC) begin
            rb = s_q.reloc;
        end else if (paddr[11:2] == psr_pkg::IDX_EV_CTRL) begin
            rb = s_q.ev_ctrl;
        end
        case (s_q.phase)
            psr_pkg::PH_IDLE: begin
                if (setup) begin
                    s_d.phase = psr_pkg::PH_RESP;
                    s_d.rdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rb};
                    s_d.err   = !(tgt.port_hit || tgt.cfg_hit);
                end
            end
            psr_pkg::PH_RESP: begin
                s_d.phase = psr_pkg::PH_IDLE;
                s_d.rdata = 32'h0000_0000;
                s_d.err   = 1'b0;
            end
            default: s_d.phase = psr_pkg::PH_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q       <= '0;
            s_q.phase <= psr_pkg::PH_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************
    // outputs
    // ********************************
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            pin_out[8*p +: 8]       = s_q.pins[p];
            pin_oe[8*p +: 8]        = s_q.dir[p];
            port_irq_flag[2*p +: 2] = s_q.flags[p];
        end
    end

    assign prdata  = s_q.rdata;
    assign pready  = s_q.phase[1];
    assign pslverr = s_q.err;
endmodule : psr_port_routing

// >>> testbench/psr_pin_model.sv
`timescale 1ns/1ns
module psr_pin_model #(
    parameter int NPORT = 16
) (
    input  wire logic [NPORT*8-1:0] pin_out, // offered values
    input  wire logic [NPORT*8-1:0] pin_oe,  // drive enables
    input  wire logic [NPORT*8-1:0] pin_ext, // outside drivers
    output logic      [NPORT*8-1:0] pin_in   // resolved levels
);
    // no pulls: an undriven pin shows the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_ext);
endmodule : psr_pin_model

// >>> testbench/psr_port_routing_assertions.sv
`timescale 1ns/1ns
module psr_port_routing_chk #(
    parameter int NPORT = 16
) (
    input wire logic               pclk,          // clock
    input wire logic               presetn,       // reset
    input wire logic               psel,          // select
    input wire logic               penable,       // access
    input wire logic               pwrite,        // write
    input wire logic [11:0]        paddr,         // address
    input wire logic [31:0]        pwdata,        // wdata
    input wire logic [31:0]        prdata,        // rdata
    input wire logic               pready,        // ready
    input wire logic [NPORT*8-1:0] pin_out,       // pins
    input wire logic [NPORT*8-1:0] pin_oe,        // enables
    input wire logic [NPORT*2-1:0] port_irq_flag, // flags
    input wire logic               clk_per_1x,    // 1x
    input wire logic               clk_per_2x,    // 2x
    input wire logic               clk_per_4x,    // 4x
    input wire logic [7:0]         ev_chan,       // events
    input wire logic               bus_enable,    // bus on
    input wire logic               bus_four_port, // 4 ports
    input wire logic [2:0]         bus_mode,      // memory
    input wire logic [23:0]        bus_addr,      // address
    input wire logic [3:0]         bus_chipsel    // selects
);
    logic        wr, ckv;
    logic [7:0]  ck_q, ev_q, bu_q;
    logic [31:0] rmask;
    int          ckp, evp, csp;
    assign wr  = psel && penable && pready && pwrite;
    assign ckp = 8 * (int'(ck_q[1:0]) + 1) + (ck_q[7] ? 4 : 7);
    assign evp = 8 * (int'(ck_q[5:4]) + 1) + (ck_q[7] ? 4 : 7);
    assign csp = bu_q[1] ? (bu_q[0] ? 36 : 44) : (bu_q[0] ? 84 : 60);
    assign ckv = ck_q[3] ? (!ck_q[2] && clk_per_4x) : (ck_q[2] ? clk_per_2x : clk_per_1x);
    assign rmask = paddr == 12'h014 ? 32'hFFFFFFF0 : paddr == 12'h018 ? 32'hFFFFFFF8 :
                   (paddr[11:6] == 6'h01 && paddr[3:2] == 2'h3) ? 32'hFFFFFFFC : 32'hFFFFFF00;
    // shadows rebuilt from bus writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_q <= 8'h00;
            ev_q <= 8'h00;
            bu_q <= 8'h00;
        end else if (wr) begin
            case (paddr)
                12'h010: ck_q <= pwdata[7:0];
                12'h014: bu_q <= pwdata[7:0];
                12'h018: ev_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    // ****
    // properties
    // ****
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_dirw;
        wr && paddr == 12'h100;
    endsequence
    property p_ready;
        s_setup |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_clk;
        ck_q[1:0] != 2'h0 && $stable(ck_q) |-> pin_out[ckp] == $past(ckv);
    endproperty
    a_clk: assert property (p_clk) else $error("clock pin wrong");
    property p_evt;
        ck_q[5:4] != 2'h0 && ck_q[5:4] != ck_q[1:0] && $stable(ck_q) && $stable(ev_q)
            |-> pin_out[evp] == $past(ev_chan[ev_q[2:0]]);
    endproperty
    a_evt: assert property (p_evt) else $error("event pin wrong");
    property p_cs;
        $stable(bu_q) && bu_q[1:0] != 2'h3 && $past(bus_enable)
            |-> pin_out[csp +: 4] == $past(bus_chipsel);
    endproperty
    a_cs: assert property (p_cs) else $error("chip select pins wrong");
    property p_adr;
        $stable(bu_q) && bu_q[3:2] == 2'h0 && bu_q[1:0] != 2'h2
            && $past(bus_enable && bus_four_port && bus_mode == 3'h1)
            |-> pin_out[47:40] == $past(bus_addr[23:16]);
    endproperty
    a_adr: assert property (p_adr) else $error("address pins wrong");
    property p_rsv;
        pready && !pwrite |-> (prdata & rmask) == 32'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_flag;
        !$past(wr) |-> (port_irq_flag & $past(port_irq_flag)) == $past(port_irq_flag);
    endproperty
    a_flag: assert property (p_flag) else $error("flag lost");
    property p_oe;
        s_dirw |=> ##1 pin_oe[7:0] == $past(pwdata[7:0], 2);
    endproperty
    a_oe: assert property (p_oe) else $error("enable not direction");
endmodule : psr_port_routing_chk

bind psr_port_routing psr_port_routing_chk #(.NPORT(NPORT)) psr_port_routing_chk_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pin_out,
    .pin_oe, .port_irq_flag, .clk_per_1x, .clk_per_2x, .clk_per_4x, .ev_chan, .bus_enable,
    .bus_four_port, .bus_mode, .bus_addr, .bus_chipsel);

// >>> testbench/psr_port_routing_tb.sv
`timescale 1ns/1ns
module psr_port_routing_tb;
    localparam int NP = 16;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, er, busr;
    logic             clk_per_1x, clk_per_2x, clk_per_4x, bus_enable, bus_four_port;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, seed, rd, rb;
    logic [NP*8-1:0]  pin_in, pin_out, pin_oe, pin_ext, irq0_src_mask, irq1_src_mask;
    logic [NP*24-1:0] sense_cfg;
    logic [NP*2-1:0]  port_irq_flag;
    logic [15:0]      mp;
    logic [7:0]       ev_chan, v, w;
    logic [2:0]       bus_mode;
    logic [23:0]      bus_addr;
    logic [3:0]       bus_chipsel;
    int               err_total, checks, cyc;
    psr_port_routing #(.NPORT(NP)) psr_port_routing_inst (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
        .sense_cfg, .irq0_src_mask, .irq1_src_mask, .port_irq_flag, .clk_per_1x, .clk_per_2x,
        .clk_per_4x, .ev_chan, .bus_enable, .bus_four_port, .bus_mode, .bus_addr,
        .bus_chipsel);
    psr_pin_model #(.NPORT(NP)) psr_pin_model_inst (.pin_out, .pin_oe, .pin_ext, .pin_in);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [11:0] ca(input logic [9:0] i);
        return {i, 2'b00};
    endfunction : ca
    function automatic logic [11:0] va(input int n, input int s);
        return 12'((psr_pkg::IDX_VPORT + 4 * n + s) * 4);
    endfunction : va
    function automatic logic [11:0] pa(input int p, input int s);
        return 12'((psr_pkg::IDX_PPORT + psr_pkg::PPORT_SPAN * p + 4 * s) * 4);
    endfunction : pa
    function automatic logic [31:0] lvl(input logic [7:0] d, o, e);
        return {24'h0, (d & o) | (~d & e)};
    endfunction : lvl
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        rd = xs();
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, rd[31:8], d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask : rdc
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    always @(posedge pclk) begin
        rb = xs();
        {clk_per_4x, clk_per_2x, clk_per_1x} <= rb[2:0];
        ev_chan <= rb[10:3];
        bus_chipsel <= rb[14:11];
        bus_enable <= busr & rb[15];
        bus_four_port <= rb[16];
        bus_mode <= 3'(rb[19:17] % 5);
        bus_addr <= rb[31:8];
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        seed = 32'h1f043652;
        {presetn, psel, penable, pwrite, busr} = '0;
        {paddr, pwdata, pin_ext, sense_cfg, irq0_src_mask, irq1_src_mask, mp} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 2; i < 7; i++) rdc(ca(10'(i)), 32'h0);
        for (int i = 0; i < 16; i++) if (i % 4 != 2) rdc(va(i / 4, i % 4), 32'h0);
        $display("test 1 done");
        pin_ext <= {xs(), xs(), xs(), xs()};
        for (int c = 0; c < 16; c++) begin
            mp[4 * (c % 4) +: 4] = 4'(c);
            apb(1'b1, ca(c % 4 < 2 ? psr_pkg::IDX_VMAP_A : psr_pkg::IDX_VMAP_B),
                c % 4 < 2 ? mp[7:0] : mp[15:8]);
            {v, w} = 16'(xs());
            apb(1'b1, va(c % 4, 0), v);
            rdc(pa(c, 0), {24'h0, v});
            chk({24'h0, pin_oe[8 * c +: 8]}, {24'h0, v});
            apb(1'b1, pa(c, 1), w);
            rdc(va(c % 4, 1), {24'h0, w});
            rdc(va(c % 4, 2), lvl(v, w, pin_ext[8 * c +: 8]));
        end
        $display("test 2 done");
        sense_cfg[72 +: 12] <= 12'hFFF;
        apb(1'b1, ca(psr_pkg::IDX_VMAP_A), 8'h03);
        apb(1'b1, va(0, 0), 8'h00);
        repeat (2) @(posedge pclk);
        rdc(va(0, 2), {24'h0, pin_ext[31:24] & 8'hF0});
        apb(1'b0, 12'h01C, 8'h00);
        chk({rd[31:1], er}, 32'h1);
        $display("test 3 done");
        apb(1'b1, ca(psr_pkg::IDX_VMAP_A), 8'h06);
        apb(1'b1, pa(6, 0), 8'h00);
        sense_cfg[144 +: 3] <= 3'h1;
        {irq1_src_mask[48], irq0_src_mask[48], pin_ext[48]} <= 3'b110;
        repeat (3) @(posedge pclk);
        pin_ext[48] <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({30'h0, port_irq_flag[13:12]}, 32'h3);
        rdc(va(0, 3), 32'h3);
        apb(1'b1, va(0, 3), 8'h00);
        rdc(va(0, 3), 32'h3);
        apb(1'b1, va(0, 3), 8'h02);
        rdc(pa(6, 3), 32'h1);
        apb(1'b1, pa(6, 3), 8'hFF);
        rdc(va(0, 3), 32'h0);
        $display("test 4 done");
        busr <= 1'b1;
        apb(1'b1, pa(0, 0), 8'hA5);
        for (int i = 0; i < 8; i++) begin
            v = {i[2], 1'b0, i[2:1], i[1:0], i[1:0]};
            apb(1'b1, ca(psr_pkg::IDX_CLK_EV), v);
            rdc(ca(psr_pkg::IDX_CLK_EV), {24'h0, v});
            apb(1'b1, ca(psr_pkg::IDX_EV_CTRL), {5'h0, i[2:0]});
            rdc(ca(psr_pkg::IDX_EV_CTRL), {29'h0, i[2:0]});
            apb(1'b1, ca(psr_pkg::IDX_BUS_RELOC), {4'h0, i[1:0], i[2:1]});
            rdc(ca(psr_pkg::IDX_BUS_RELOC), {28'h0, i[1:0], i[2:1]});
            repeat (12) @(posedge pclk);
        end
        $display("test 5 done");
        end_sim();
    end
endmodule : psr_port_routing_tb
